// ===== core/buck_channel.sv
/*
  one buck channel: turn-on delay, soft-start reference ramp, mode pass-through.
  assumes enable and kill come synchronous to pclk from the register block.
*/
`timescale 1ns/1ps
`default_nettype none
module buck_channel #(
  parameter int unsigned DLY_STEP = supply_ctrl_pkg::DLY_STEP_CYC_DEF
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // register block side
  buck_ctrl_if.chan       bk
);
  import supply_ctrl_pkg::*;

  localparam logic [CNT_W-1:0] SS_STEP_LD = CNT_W'(SS_STEP_CYC - 1);
  localparam logic [REF_W-1:0] REF_MAX    = REF_W'(REF_STEPS);

  buck_state_t      st_r;
  buck_state_t      st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [REF_W-1:0] ref_r;
  logic             run_r;
  logic             rdy_r;
  logic             pwm_r;
  logic             off_req;

  // ************************************************************
  // sequencing
  // ************************************************************
  assign off_req = ~bk.en | bk.kill;

  function automatic logic [CNT_W-1:0] dly_cycles(input logic [BK_DLY_W-1:0] code);
    dly_cycles = CNT_W'(int'(DLY_MULT[code]) * int'(DLY_STEP));
  endfunction

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ST_OFF: begin
        if (!off_req) begin
          st_nxt  = ST_DLY;
          cnt_nxt = dly_cycles(bk.dly_code);
        end
      end
      ST_DLY: begin
        if (off_req) begin
          st_nxt = ST_OFF;
        end else if (cnt_r == '0) begin
          st_nxt  = ST_RAMP;
          cnt_nxt = SS_STEP_LD;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_RAMP: begin
        if (off_req) begin
          st_nxt = ST_OFF;
        end else if (cnt_r == '0) begin
          if (ref_r == REF_MAX) begin
            st_nxt = ST_ON;
          end else begin
            cnt_nxt = SS_STEP_LD;
          end
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_ON: begin
        if (off_req) begin
          st_nxt = ST_OFF;
        end
      end
      default: begin
        st_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r  <= ST_OFF;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ************************************************************
  // reference ramp and outputs
  // ************************************************************
  // the reference climbs one step per interval instead of jumping to full scale
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_r <= '0;
    end else if (st_nxt == ST_OFF || st_nxt == ST_DLY) begin
      ref_r <= '0;
    end else if (st_r == ST_RAMP && cnt_r == '0 && ref_r != REF_MAX) begin
      ref_r <= ref_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= 1'b0;
      rdy_r <= 1'b0;
      pwm_r <= 1'b0;
    end else begin
      run_r <= (st_nxt == ST_RAMP) || (st_nxt == ST_ON);
      rdy_r <= (st_nxt == ST_ON);
      pwm_r <= bk.mode;
    end
  end

  assign bk.run       = run_r;
  assign bk.ready     = rdy_r;
  assign bk.refv      = ref_r;
  assign bk.force_pwm = pwm_r;

endmodule
`default_nettype wire

// ===== core/buck_ctrl_if.sv
/*
  control and status bundle between the register block and one buck channel.
  assumes both ends run on the same register clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface buck_ctrl_if;
  logic                                   en;
  logic                                   kill;
  logic [supply_ctrl_pkg::BK_DLY_W-1:0]   dly_code;
  logic                                   mode;
  logic                                   run;
  logic                                   force_pwm;
  logic [supply_ctrl_pkg::REF_W-1:0]      refv;
  logic                                   ready;

  modport ctrl (output en, kill, dly_code, mode, input run, force_pwm, refv, ready);
  modport chan (input en, kill, dly_code, mode, output run, force_pwm, refv, ready);
endinterface
`default_nettype wire

// ===== core/supply_ctrl_pkg.sv
/*
  constants, register map, field layout, reset values and state codes for the supply
  monitor and buck regulator control block.
  assumes a 10 MHz register clock; shared by the top block and its buck channels.
*/
package supply_ctrl_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int CLK_HZ           = 10_000_000;
  localparam int CYC_PER_US       = CLK_HZ / 1_000_000;
  localparam int SS_TIME_US       = 400;
  localparam int SS_CYC           = SS_TIME_US * CYC_PER_US;
  localparam int REF_W            = 8;
  localparam int REF_STEPS        = (1 << REF_W) - 1;
  // rounds down so the whole ramp never exceeds the soft-start time
  localparam int SS_STEP_CYC      = SS_CYC / REF_STEPS;
  localparam int DLY_STEP_US      = 1000;
  localparam int DLY_STEP_CYC_DEF = DLY_STEP_US * CYC_PER_US;
  localparam int CNT_W            = 24;
  // turn-on delay in units of one delay step, indexed by the 3-bit delay code
  localparam logic [6:0] DLY_MULT [8] = '{7'h00, 7'h01, 7'h02, 7'h04,
                                          7'h08, 7'h10, 7'h20, 7'h40};

  // ************************************************************
  // threshold decode
  // ************************************************************
  localparam int TH_W        = 12;
  localparam int TH_BASE_MV  = 2300;
  localparam int TH_STEP_MV  = 100;
  localparam int TH_HYST_MV  = 200;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int N_BUCK = 3;
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_BUCK     = 12'h010;

  localparam int CTRL_CODE_LSB = 0;
  localparam int CTRL_CODE_W   = 4;
  localparam int CTRL_SEL_BIT  = 4;
  localparam int ST_LOW_BIT    = 0;
  localparam int ST_OT_BIT     = 1;
  localparam int ST_RUN_LSB    = 2;
  localparam int ST_RDY_LSB    = 5;
  localparam int IRQ_SUPPLY    = 0;
  localparam int IRQ_OTEMP     = 1;
  localparam int IRQ_W         = 2;
  localparam int BK_STRIDE     = 8;
  localparam int BK_EN_BIT     = 0;
  localparam int BK_DLY_LSB    = 1;
  localparam int BK_DLY_W      = 3;
  localparam int BK_MODE_BIT   = 4;

  localparam logic [CTRL_CODE_W-1:0] THR_CODE_RST  = 4'h7;
  localparam logic                   FAULT_SEL_RST = 1'b1;
  localparam logic [IRQ_W-1:0]       IRQ_MASK_RST  = 2'h0;
  localparam logic [N_BUCK-1:0]      BK_EN_RST     = 3'h0;
  localparam logic [N_BUCK-1:0]      BK_MODE_RST   = 3'h0;
  localparam logic [BK_DLY_W-1:0]    BK_DLY_RST    = 3'h0;

  // ************************************************************
  // buck channel states
  // ************************************************************
  typedef enum logic [3:0] {
    ST_OFF  = 4'h1,
    ST_DLY  = 4'h2,
    ST_RAMP = 4'h4,
    ST_ON   = 4'h8
  } buck_state_t;

endpackage

// ===== core/supply_monitor_regulator_ctrl.sv
/*
  supply monitor, fault handling and buck enable control behind an apb slave.
  assumes the comparator and over-temperature inputs are synchronous to pclk and that
  the analog side applies the rising hysteresis; the interrupt pin is open drain.
*/
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Function
// - threshold code decodes to 2.3 V plus 0.1 V per step, up to 3.8 V
// - fault select 1 and alarm unmasked: supply drop asserts active-low interrupt
// - supply alarm holds until supply recovers and host has read status
// - fault select 0: supply drop disables every regulator at once
// - over-temperature disables all regulators and blocks enables until cleared
// - an enabled buck ramps its reference over 400 us soft start
// - each buck has a host-written enable bit, 1 on and 0 off
// - each buck waits a programmed 3-bit turn-on delay before switching on
// - mode bit 0 allows light-load power saving, 1 forces fixed frequency
// - supply low status reads 1 below threshold, 0 above
// - threshold code resets to the 3.0 V setting
// - interrupt pin open drain, low while unmasked source pending; masked at reset
module supply_monitor_regulator_ctrl #(
  parameter int unsigned DLY_STEP_CYC = supply_ctrl_pkg::DLY_STEP_CYC_DEF
) (
  // clock and reset
  input  wire logic                                      pclk,
  input  wire logic                                      presetn,
  // apb slave
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [supply_ctrl_pkg::ADDR_W-1:0]        paddr,
  input  wire logic [supply_ctrl_pkg::DATA_W-1:0]        pwdata,
  input  wire logic [3:0]                                pstrb,
  output logic      [supply_ctrl_pkg::DATA_W-1:0]        prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  // analog monitor side
  input  wire logic                                      supply_below,
  input  wire logic                                      over_temp,
  output logic      [supply_ctrl_pkg::CTRL_CODE_W-1:0]   supply_threshold_code,
  output logic      [supply_ctrl_pkg::TH_W-1:0]          threshold_fall_mv,
  output logic      [supply_ctrl_pkg::TH_W-1:0]          threshold_rise_mv,
  // open-drain interrupt pin
  output logic                                           interrupt_request_low_o,
  output logic                                           interrupt_request_low_oe,
  // buck regulators, index 0 buck_one, 1 buck_two, 2 buck_three
  output logic      [supply_ctrl_pkg::N_BUCK-1:0]        buck_run,
  output logic      [supply_ctrl_pkg::N_BUCK-1:0]        buck_ready,
  output logic      [supply_ctrl_pkg::N_BUCK-1:0]        buck_force_pwm,
  output logic      [supply_ctrl_pkg::N_BUCK-1:0][supply_ctrl_pkg::REF_W-1:0] buck_ref
);
  import supply_ctrl_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  logic [CTRL_CODE_W-1:0]            thr_code_r;
  logic                              fault_sel_r;
  logic [IRQ_W-1:0]                  irq_stat_r;
  logic [IRQ_W-1:0]                  irq_mask_r;
  logic [N_BUCK-1:0]                 en_r;
  logic [N_BUCK-1:0]                 mode_r;
  logic [N_BUCK-1:0][BK_DLY_W-1:0]   dly_r;
  logic                              low_r;
  logic                              low_prev_r;
  logic                              ot_r;
  logic                              ot_prev_r;
  logic                              read_seen_r;
  logic [DATA_W-1:0]                 prdata_r;
  logic                              pready_r;
  logic                              pslverr_r;
  logic                              irq_oe_r;
  logic [TH_W-1:0]                   fall_mv_r;
  logic [TH_W-1:0]                   rise_mv_r;

  logic                              setup;
  logic                              acc;
  logic                              wr_acc;
  logic                              rd_acc;
  logic                              hit_ctrl;
  logic                              hit_stat;
  logic                              hit_istat;
  logic                              hit_imask;
  logic                              hit_buck;
  logic                              hit_any;
  logic                              kill;
  logic                              low_fall;
  logic                              ot_rise;
  logic                              sup_set;
  logic                              sup_clr;
  logic [N_BUCK-1:0]                 run_w;
  logic [N_BUCK-1:0]                 rdy_w;
  logic [DATA_W-1:0]                 ctrl_rd;
  logic [DATA_W-1:0]                 stat_rd;
  logic [DATA_W-1:0]                 buck_rd;
  logic [DATA_W-1:0]                 rd_mux;
  logic [DATA_W-1:0]                 wv_ctrl;
  logic [DATA_W-1:0]                 wv_mask;
  logic [DATA_W-1:0]                 wv_buck;
  logic [DATA_W-1:0]                 w1c;

  // keeps the old value in every byte lane whose strobe is low
  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // ************************************************************
  // apb decode
  // ************************************************************
  assign setup     = psel & ~penable;
  assign acc       = psel & penable & pready_r;
  assign wr_acc    = acc & pwrite;
  assign rd_acc    = acc & ~pwrite;
  assign hit_ctrl  = (paddr == OFS_CTRL);
  assign hit_stat  = (paddr == OFS_STATUS);
  assign hit_istat = (paddr == OFS_IRQ_STAT);
  assign hit_imask = (paddr == OFS_IRQ_MASK);
  assign hit_buck  = (paddr == OFS_BUCK);
  assign hit_any   = hit_ctrl | hit_stat | hit_istat | hit_imask | hit_buck;

  always_comb begin
    ctrl_rd = '0;
    stat_rd = '0;
    buck_rd = '0;
    ctrl_rd[CTRL_CODE_LSB +: CTRL_CODE_W] = thr_code_r;
    ctrl_rd[CTRL_SEL_BIT]                 = fault_sel_r;
    stat_rd[ST_LOW_BIT]                   = low_r;
    stat_rd[ST_OT_BIT]                    = ot_r;
    stat_rd[ST_RUN_LSB +: N_BUCK]         = run_w;
    stat_rd[ST_RDY_LSB +: N_BUCK]         = rdy_w;
    for (int i = 0; i < N_BUCK; i++) begin
      buck_rd[i*BK_STRIDE + BK_EN_BIT]               = en_r[i];
      buck_rd[i*BK_STRIDE + BK_DLY_LSB +: BK_DLY_W]  = dly_r[i];
      buck_rd[i*BK_STRIDE + BK_MODE_BIT]             = mode_r[i];
    end
  end

  always_comb begin
    rd_mux = '0;
    if (hit_ctrl) begin
      rd_mux = ctrl_rd;
    end else if (hit_stat) begin
      rd_mux = stat_rd;
    end else if (hit_istat) begin
      rd_mux[IRQ_W-1:0] = irq_stat_r;
    end else if (hit_imask) begin
      rd_mux[IRQ_W-1:0] = irq_mask_r;
    end else if (hit_buck) begin
      rd_mux = buck_rd;
    end
  end

  assign wv_ctrl = lane_merge(ctrl_rd, pwdata, pstrb);
  assign wv_mask = lane_merge({{(DATA_W-IRQ_W){1'b0}}, irq_mask_r}, pwdata, pstrb);
  assign wv_buck = lane_merge(buck_rd, pwdata, pstrb);
  assign w1c     = lane_merge('0, pwdata, pstrb);

  // read data is latched in the setup cycle so the slave answers with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
      pready_r  <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup) begin
        prdata_r  <= pwrite ? '0 : rd_mux;
        pslverr_r <= ~hit_any;
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_code_r  <= THR_CODE_RST;
      fault_sel_r <= FAULT_SEL_RST;
    end else if (wr_acc && hit_ctrl) begin
      thr_code_r  <= wv_ctrl[CTRL_CODE_LSB +: CTRL_CODE_W];
      fault_sel_r <= wv_ctrl[CTRL_SEL_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= IRQ_MASK_RST;
    end else if (wr_acc && hit_imask) begin
      irq_mask_r <= wv_mask[IRQ_W-1:0];
    end
  end

  // a fault outranks a host write, so enables cannot be set while it lasts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r   <= BK_EN_RST;
      mode_r <= BK_MODE_RST;
      dly_r  <= {N_BUCK{BK_DLY_RST}};
    end else begin
      for (int i = 0; i < N_BUCK; i++) begin
        if (kill) begin
          en_r[i] <= 1'b0;
        end else if (wr_acc && hit_buck) begin
          en_r[i] <= wv_buck[i*BK_STRIDE + BK_EN_BIT];
        end
        if (wr_acc && hit_buck) begin
          dly_r[i]  <= wv_buck[i*BK_STRIDE + BK_DLY_LSB +: BK_DLY_W];
          mode_r[i] <= wv_buck[i*BK_STRIDE + BK_MODE_BIT];
        end
      end
    end
  end

  // ************************************************************
  // supply monitor and faults
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r      <= 1'b0;
      low_prev_r <= 1'b0;
      ot_r       <= 1'b0;
      ot_prev_r  <= 1'b0;
    end else begin
      low_r      <= supply_below;
      low_prev_r <= low_r;
      ot_r       <= over_temp;
      ot_prev_r  <= ot_r;
    end
  end

  assign low_fall = low_r & ~low_prev_r;
  assign ot_rise  = ot_r & ~ot_prev_r;
  assign kill     = ot_r | (low_r & ~fault_sel_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_mv_r <= '0;
      rise_mv_r <= '0;
    end else begin
      fall_mv_r <= TH_W'(TH_BASE_MV + TH_STEP_MV * int'(thr_code_r));
      rise_mv_r <= TH_W'(TH_BASE_MV + TH_HYST_MV + TH_STEP_MV * int'(thr_code_r));
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  assign sup_set = low_fall & fault_sel_r;
  assign sup_clr = irq_stat_r[IRQ_SUPPLY] & ~low_r & read_seen_r;

  // a status read only counts once the alarm is standing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_seen_r <= 1'b0;
    end else if (sup_set || sup_clr) begin
      read_seen_r <= 1'b0;
    end else if (rd_acc && hit_stat && irq_stat_r[IRQ_SUPPLY]) begin
      read_seen_r <= 1'b1;
    end
  end

  // set wins over clear for both sticky bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      if (sup_set) begin
        irq_stat_r[IRQ_SUPPLY] <= 1'b1;
      end else if (sup_clr) begin
        irq_stat_r[IRQ_SUPPLY] <= 1'b0;
      end
      if (ot_rise) begin
        irq_stat_r[IRQ_OTEMP] <= 1'b1;
      end else if (wr_acc && hit_istat && w1c[IRQ_OTEMP]) begin
        irq_stat_r[IRQ_OTEMP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ************************************************************
  // buck channels
  // ************************************************************
  for (genvar g = 0; g < N_BUCK; g++) begin : g_buck
    buck_ctrl_if bk ();
    assign bk.en       = en_r[g];
    assign bk.kill     = kill;
    assign bk.dly_code = dly_r[g];
    assign bk.mode     = mode_r[g];
    buck_channel #(
      .DLY_STEP (DLY_STEP_CYC)
    ) u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .bk      (bk.chan)
    );
    assign run_w[g]          = bk.run;
    assign rdy_w[g]          = bk.ready;
    assign buck_force_pwm[g] = bk.force_pwm;
    assign buck_ref[g]       = bk.refv;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata                   = prdata_r;
  assign pready                   = pready_r;
  assign pslverr                  = pslverr_r;
  assign supply_threshold_code    = thr_code_r;
  assign threshold_fall_mv        = fall_mv_r;
  assign threshold_rise_mv        = rise_mv_r;
  // the pin is only ever pulled low; the pull-up gives the high level
  assign interrupt_request_low_o  = 1'b0;
  assign interrupt_request_low_oe = irq_oe_r;
  assign buck_run                 = run_w;
  assign buck_ready               = rdy_w;

endmodule
`default_nettype wire

// ===== dv/host_model.sv
/* host side: apb master task and the pulled-up interrupt pin. assumes one clock */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic pclk, pready, pslverr, irq_oe,
  input wire logic [31:0] prdata,
  output logic psel, penable, pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic irq_pin);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // released pin floats up through the pull-up
  assign irq_pin = irq_oe ? 1'b0 : 1'b1;
  // waits an edge first so back-to-back calls never drive psel twice in one step
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== dv/supply_monitor_regulator_ctrl_props.sv
/* checker on the top block ports; bound below. assumes one pclk domain */
`timescale 1ns/1ps
`default_nettype none
module smrc_props
  import supply_ctrl_pkg::*;
#(parameter int unsigned DLY_STEP_CYC = DLY_STEP_CYC_DEF) (
  input wire logic pclk, presetn, supply_below, over_temp,
  input wire logic [CTRL_CODE_W-1:0] supply_threshold_code,
  input wire logic [TH_W-1:0] threshold_fall_mv, threshold_rise_mv,
  input wire logic interrupt_request_low_o, interrupt_request_low_oe,
  input wire logic [N_BUCK-1:0] buck_run, buck_ready,
  input wire logic [N_BUCK-1:0][REF_W-1:0] buck_ref);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  fall_map_a: assert property ($past(presetn) |->
    threshold_fall_mv == 12'(2300 + 100 * $past(supply_threshold_code))) else $error("fall");
  rise_hyst_a: assert property ($past(presetn) |->
    threshold_rise_mv == threshold_fall_mv + 12'd200) else $error("rise");
  ot_off_a: assert property (over_temp [*5] |-> buck_run == '0) else $error("ot");
  od_low_a: assert property (interrupt_request_low_o == 1'b0) else $error("od");
  irq_hold_a: assert property ($fell(interrupt_request_low_oe) |-> !supply_below)
    else $error("hold");
  irq_cause_a: assert property ($rose(interrupt_request_low_oe) |->
    supply_below || over_temp) else $error("cause");
  soft_start_a: assert property ($rose(buck_run[0]) |-> (buck_ref[0] == 8'h00) [*8])
    else $error("ramp");
  ramp_end_a: assert property ($rose(buck_ready[0]) |-> buck_ref[0] == 8'hff)
    else $error("ready");
endmodule
bind supply_monitor_regulator_ctrl smrc_props #(.DLY_STEP_CYC(DLY_STEP_CYC)) i_props (
  .pclk(pclk), .presetn(presetn), .supply_below(supply_below), .over_temp(over_temp),
  .supply_threshold_code(supply_threshold_code), .threshold_fall_mv(threshold_fall_mv),
  .threshold_rise_mv(threshold_rise_mv), .interrupt_request_low_o(interrupt_request_low_o),
  .interrupt_request_low_oe(interrupt_request_low_oe), .buck_run(buck_run),
  .buck_ready(buck_ready), .buck_ref(buck_ref));
`default_nettype wire

// ===== dv/supply_monitor_regulator_ctrl_tb_top.sv
/* bench top: host model drives apb, bench drives the analog inputs */
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_regulator_ctrl_tb_top;
  import supply_ctrl_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, supply_below = 1'b0, over_temp = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq_oe, irq_pin, err;
  logic [11:0] paddr, fall_mv;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] run, rdy, fpwm;
  logic [2:0][7:0] refv;
  int miscompares = 0, tests_run = 0, n;
  always #50 pclk = ~pclk;
  // short delay step keeps the turn-on waits to a few cycles
  supply_monitor_regulator_ctrl #(.DLY_STEP_CYC(4)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .supply_below,
    .over_temp, .supply_threshold_code(), .threshold_fall_mv(fall_mv), .threshold_rise_mv(),
    .interrupt_request_low_o(), .interrupt_request_low_oe(irq_oe), .buck_run(run),
    .buck_ready(rdy), .buck_force_pwm(fpwm), .buck_ref(refv));
  host_model i_host (.pclk, .pready, .pslverr, .irq_oe, .prdata, .psel, .penable, .pwrite,
    .paddr, .pwdata, .irq_pin);
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q, err);
  endtask
  task automatic rd(input logic [11:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, err);
  endtask
  task automatic wait_hi(input bit r, input int b);
    n = 0;
    while ((r ? rdy[b] : run[b]) !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk("wait", 1, n < 5000);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic t_regs();
    rd(OFS_CTRL);
    chk("ctrl rst", 32'h17, q);
    rd(OFS_IRQ_MASK);
    chk("mask rst", 32'h0, q);
    rd(12'h020);
    chk("unmapped", 32'h1, {q[30:0], err});
    for (int c = 0; c < 16; c++) begin
      wr(OFS_CTRL, 32'h10 | c);
      cyc(2);
      chk("fall", 2300 + 100 * c, fall_mv);
    end
    wr(OFS_CTRL, 32'h17);
    $display("registers done");
  endtask
  task automatic t_alarm();
    wr(OFS_IRQ_MASK, 32'h1);
    supply_below <= 1'b1;
    cyc(5);
    chk("pin low", 0, irq_pin);
    supply_below <= 1'b0;
    cyc(5);
    chk("pin held", 0, irq_pin);
    rd(OFS_STATUS);
    chk("low bit", 0, q[0]);
    cyc(4);
    chk("pin free", 1, irq_pin);
    $display("alarm done");
  endtask
  task automatic t_buck();
    wr(OFS_BUCK, 32'h13);
    wait_hi(0, 0);
    chk("delay", 1, n > 4 && n < 10);
    chk("pwm", 1, fpwm[0]);
    wait_hi(1, 0);
    chk("ramp", 1, n > 3800 && refv[0] == 8'hff);
    wr(OFS_BUCK, 32'h3);
    cyc(2);
    chk("pwm off", 0, fpwm[0]);
    wr(OFS_BUCK, 32'h0);
    cyc(3);
    chk("off", 0, run[0]);
    wr(OFS_BUCK, 32'h7);
    wait_hi(0, 0);
    chk("delay 3", 1, n > 16 && n < 22);
    $display("buck done");
  endtask
  task automatic t_kill();
    wr(OFS_CTRL, 32'h07);
    for (int k = 0; k < 2; k++) begin
      wr(OFS_BUCK, 32'h010101);
      wait_hi(0, 2);
      chk("run", 1, run[2]);
      {over_temp, supply_below} <= k ? 2'b10 : 2'b01;
      cyc(5);
      chk("kill", 0, run);
      wr(OFS_BUCK, 32'h1);
      cyc(8);
      chk("blocked", 0, run);
      rd(OFS_STATUS);
      chk("status", k ? 2 : 1, q[1:0]);
      {over_temp, supply_below} <= 2'b00;
      cyc(4);
    end
    wr(OFS_CTRL, 32'h17);
    chk("masked", 1, irq_pin);
    wr(OFS_BUCK, 32'h1);
    wait_hi(0, 0);
    chk("reenable", 1, n < 20);
    $display("kill done");
  endtask
  initial begin
    cyc(4);
    presetn <= 1'b1;
    t_regs();
    t_alarm();
    t_buck();
    t_kill();
    end_sim();
  end
  initial begin
    cyc(20000);
    miscompares++;
    end_sim();
  end
endmodule
`default_nettype wire
